// ==== design/scal_reg8.sv ====
// one 8-bit configuration register with software write, calibration load and wake restore
module scal_reg8 #(
    parameter logic [7:0] RESET    = 8'h00,
    parameter logic [7:0] MASK     = 8'hff,
    parameter bit         VOLATILE = 1'b0
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       wake,
    input  wire logic       sw_we,
    input  wire logic [7:0] sw_data,
    input  wire logic       hw_we,
    input  wire logic [7:0] hw_data,
    output logic      [7:0] q
);

    // unused bits never store a one; a software write overrides a calibration load
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= RESET;
        end else if (VOLATILE && wake) begin
            q <= RESET;
        end else if (sw_we) begin
            q <= sw_data & MASK;
        end else if (hw_we) begin
            q <= hw_data & MASK;
        end
    end

endmodule

// ==== design/scal_regbank.sv ====
// synthesizer calibration and test register bank
// Overview of operation
// - Bits 7:6 of synth_cal_charge_pump are a read-write calibration setting resetting to 2.
// - Bits 5:4 of synth_cal_charge_pump reset to 2 and skip charge pump calibration at zero.
// - Bits 3:0 of synth_cal_charge_pump hold the charge pump result, resetting to 9.
// - Bit 5 of synth_cal_vco_current picks the high VCO core when set and resets to 0.
// - Bits 4:0 of synth_cal_vco_current hold the VCO current result or override, reset 10.
// - Bits 5:0 of synth_cal_coarse_tune hold the coarse tuning setting, reset 0x20.
// - Bits 6:0 of synth_cal_control are a read-write control value resetting to 0x0d.
// - The reserved and test registers lose their contents in sleep and must be rewritten.
// - On wake test_settings_high drives 0x88 or 0x81 inside by the retention setting.
// - On wake a read of test_settings_high returns 0x88 whatever the retention setting.
// - On wake test_settings_mid drives 0x31 or 0x35 inside by the retention setting.
// - On wake a read of test_settings_mid returns 0x31 whatever the retention setting.
// - Bit 1 of test_settings_low enables VCO choice calibration, reset 1; rest 000010, 1.
module scal_regbank (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire scal_pkg::scal_req_t  req,
    input  wire scal_pkg::scal_result_t cal_result,
    input  wire logic                 sleep,
    input  wire logic                 converter_retention,
    output logic [7:0]                rdata,
    output logic                      rvalid,
    output scal_pkg::scal_cfg_t       cfg
);

    localparam int N = scal_pkg::NREG;

    logic [N-1:0][7:0] qv;
    logic [N-1:0][7:0] hw_data;
    logic [N-1:0]      hw_we;
    logic [N-1:0]      sw_we;
    logic              sleep_q;
    logic              wake;
    logic              hi_forced;
    logic              mid_forced;

    // ------------------------------------------------------------------
    // sleep exit detection
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sleep_q <= 1'b0;
        end else begin
            sleep_q <= sleep;
        end
    end

    assign wake = sleep_q & ~sleep;

    // ------------------------------------------------------------------
    // write decode and calibration loads
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < N; i++) begin
            sw_we[i]   = req.we && !sleep && (req.addr == scal_pkg::REG_OFF[i]);
            hw_we[i]   = 1'b0;
            hw_data[i] = qv[i];
        end
        // calibration result lands only in its own field
        hw_we[scal_pkg::IX_CP]            = cal_result.cp_we;
        hw_data[scal_pkg::IX_CP][3:0]     = cal_result.cp_res;
        hw_we[scal_pkg::IX_VCO]           = cal_result.vco_we;
        hw_data[scal_pkg::IX_VCO][4:0]    = cal_result.vco_cur;
        hw_we[scal_pkg::IX_COARSE]        = cal_result.coarse_we;
        hw_data[scal_pkg::IX_COARSE][5:0] = cal_result.coarse;
    end

    // ------------------------------------------------------------------
    // register slots
    // ------------------------------------------------------------------
    // reserved and test slots restore their reset value on wake
    for (genvar g = 0; g < N; g++) begin : g_reg
        scal_reg8 #(
            .RESET    (scal_pkg::REG_RST[g]),
            .MASK     (scal_pkg::REG_MASK[g]),
            .VOLATILE (scal_pkg::REG_VOLATILE[g])
        ) u_reg (
            .clock   (clock),
            .rst_n   (rst_n),
            .wake    (wake),
            .sw_we   (sw_we[g]),
            .sw_data (req.wdata),
            .hw_we   (hw_we[g]),
            .hw_data (hw_data[g]),
            .q       (qv[g])
        );
    end

    // ------------------------------------------------------------------
    // wake-forced analog values for the test registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hi_forced <= 1'b0;
        end else if (wake) begin
            hi_forced <= 1'b1;
        end else if (sw_we[scal_pkg::IX_T_HI]) begin
            hi_forced <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mid_forced <= 1'b0;
        end else if (wake) begin
            mid_forced <= 1'b1;
        end else if (sw_we[scal_pkg::IX_T_MID]) begin
            mid_forced <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------
    // stored value is returned, never the forced analog value
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.re;
            if (req.re) begin
                rdata <= 8'h00;
                for (int i = 0; i < N; i++) begin
                    if (req.addr == scal_pkg::REG_OFF[i]) begin
                        rdata <= qv[i];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration toward the synthesizer and analog part
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= '0;
        end else begin
            cfg.cal_cfg     <= qv[scal_pkg::IX_CP][scal_pkg::CP_CFG_LSB +: 2];
            cfg.cp_stage_en <= |qv[scal_pkg::IX_CP][scal_pkg::CP_EN_LSB +: 2];
            cfg.cp_code     <= qv[scal_pkg::IX_CP][scal_pkg::CP_RES_LSB +: 4];
            cfg.vco_core_high_select <=
                qv[scal_pkg::IX_VCO][scal_pkg::VCO_CORE_BIT];
            cfg.vco_cur     <= qv[scal_pkg::IX_VCO][scal_pkg::VCO_CUR_LSB +: 5];
            cfg.coarse      <= qv[scal_pkg::IX_COARSE][5:0];
            cfg.cal_ctrl    <= qv[scal_pkg::IX_CTRL][6:0];
            cfg.vco_choice_cal_enable <=
                qv[scal_pkg::IX_T_LO][scal_pkg::VCO_SEL_BIT];
            cfg.res_a       <= qv[scal_pkg::IX_RES_A];
            cfg.res_b       <= qv[scal_pkg::IX_RES_B];
            cfg.res_c       <= qv[scal_pkg::IX_RES_C];
            cfg.test_low    <= qv[scal_pkg::IX_T_LO];
            if (hi_forced) begin
                cfg.test_high <= converter_retention ? scal_pkg::T_HI_RET
                                                     : scal_pkg::RST_T_HI;
            end else begin
                cfg.test_high <= qv[scal_pkg::IX_T_HI];
            end
            if (mid_forced) begin
                cfg.test_mid <= converter_retention ? scal_pkg::T_MID_RET
                                                    : scal_pkg::RST_T_MID;
            end else begin
                cfg.test_mid <= qv[scal_pkg::IX_T_MID];
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_cal_cfg;
        @(posedge clock) disable iff (!rst_n)
        sw_we[scal_pkg::IX_CP] |=> ##1 (cfg.cal_cfg == $past(req.wdata[7:6], 2));
    endproperty
    a_cal_cfg:
        assert property (p_cal_cfg) else $error("cal config field not applied");

    property p_cp_stage;
        @(posedge clock) disable iff (!rst_n)
        (qv[scal_pkg::IX_CP][5:4] == 2'b00) |=> !cfg.cp_stage_en;
    endproperty
    a_cp_stage:
        assert property (p_cp_stage) else $error("charge pump stage enabled at zero");

    property p_cp_result;
        @(posedge clock) disable iff (!rst_n)
        (cal_result.cp_we && !sw_we[scal_pkg::IX_CP]) |=>
            (qv[scal_pkg::IX_CP][3:0] == $past(cal_result.cp_res)) &&
            (qv[scal_pkg::IX_CP][7:4] == $past(qv[scal_pkg::IX_CP][7:4]));
    endproperty
    a_cp_result:
        assert property (p_cp_result) else $error("charge pump result load wrong");

    property p_vco_write;
        @(posedge clock) disable iff (!rst_n)
        sw_we[scal_pkg::IX_VCO] |=> (qv[scal_pkg::IX_VCO] == ($past(req.wdata) & 8'h3f));
    endproperty
    a_vco_write:
        assert property (p_vco_write) else $error("vco current override lost");

    property p_coarse;
        @(posedge clock) disable iff (!rst_n)
        (cal_result.coarse_we && !sw_we[scal_pkg::IX_COARSE]) |=> ##1
            (cfg.coarse == $past(cal_result.coarse, 2));
    endproperty
    a_coarse:
        assert property (p_coarse) else $error("coarse tune result not visible");

    property p_wake_clear;
        @(posedge clock) disable iff (!rst_n)
        wake |=> (qv[scal_pkg::IX_RES_A] == 8'h59) && (qv[scal_pkg::IX_T_LO] == 8'h0b);
    endproperty
    a_wake_clear:
        assert property (p_wake_clear) else $error("volatile register kept contents");

    property p_hi_forced;
        @(posedge clock) disable iff (!rst_n)
        wake |=> ##1 (cfg.test_high == ($past(converter_retention) ? 8'h81 : 8'h88));
    endproperty
    a_hi_forced:
        assert property (p_hi_forced) else $error("test high analog value wrong on wake");

    property p_hi_read;
        @(posedge clock) disable iff (!rst_n)
        wake ##1 (req.re && req.addr == scal_pkg::OFF_T_HI) |=> (rdata == 8'h88);
    endproperty
    a_hi_read:
        assert property (p_hi_read) else $error("test high read not 0x88 after wake");

    property p_mid_forced;
        @(posedge clock) disable iff (!rst_n)
        wake |=> ##1 (cfg.test_mid == ($past(converter_retention) ? 8'h35 : 8'h31));
    endproperty
    a_mid_forced:
        assert property (p_mid_forced) else $error("test mid analog value wrong on wake");

    property p_mid_read;
        @(posedge clock) disable iff (!rst_n)
        wake ##1 (req.re && req.addr == scal_pkg::OFF_T_MID) |=> (rdata == 8'h31);
    endproperty
    a_mid_read:
        assert property (p_mid_read) else $error("test mid read not 0x31 after wake");

    property p_vco_sel;
        @(posedge clock) disable iff (!rst_n)
        (sw_we[scal_pkg::IX_T_LO] && !wake) |=> ##1
            (cfg.vco_choice_cal_enable == $past(req.wdata[1], 2));
    endproperty
    a_vco_sel:
        assert property (p_vco_sel) else $error("vco choice enable not applied");

    property p_unused_zero;
        @(posedge clock) disable iff (!rst_n)
        (req.re && (req.addr == scal_pkg::OFF_VCO || req.addr == scal_pkg::OFF_COARSE))
            |=> (rdata[7:6] == 2'b00);
    endproperty
    a_unused_zero:
        assert property (p_unused_zero) else $error("unused bits read nonzero");

    property p_cp_code;
        @(posedge clock) disable iff (!rst_n)
        (cal_result.cp_we && !sw_we[scal_pkg::IX_CP]) |=> ##1
            (cfg.cp_code == $past(cal_result.cp_res, 2));
    endproperty
    a_cp_code:
        assert property (p_cp_code) else $error("charge pump code not forwarded");

    property p_vco_core;
        @(posedge clock) disable iff (!rst_n)
        sw_we[scal_pkg::IX_VCO] |=> ##1
            (cfg.vco_core_high_select == $past(req.wdata[5], 2));
    endproperty
    a_vco_core:
        assert property (p_vco_core) else $error("vco core select not applied");

    property p_cal_ctrl;
        @(posedge clock) disable iff (!rst_n)
        sw_we[scal_pkg::IX_CTRL] |=> ##1 (cfg.cal_ctrl == $past(req.wdata[6:0], 2));
    endproperty
    a_cal_ctrl:
        assert property (p_cal_ctrl) else $error("calibration control not applied");

    property p_hi_hold_read;
        @(posedge clock) disable iff (!rst_n)
        (hi_forced && req.re && req.addr == scal_pkg::OFF_T_HI) |=> (rdata == 8'h88);
    endproperty
    a_hi_hold_read:
        assert property (p_hi_hold_read) else $error("test high read not 0x88 while forced");

    property p_mid_hold_read;
        @(posedge clock) disable iff (!rst_n)
        (mid_forced && req.re && req.addr == scal_pkg::OFF_T_MID) |=> (rdata == 8'h31);
    endproperty
    a_mid_hold_read:
        assert property (p_mid_hold_read) else $error("test mid read not 0x31 while forced");

    c_wake_ret: cover property (@(posedge clock) disable iff (!rst_n)
        wake && converter_retention);
    c_cp_skip: cover property (@(posedge clock) disable iff (!rst_n)
        sw_we[scal_pkg::IX_CP] && req.wdata[5:4] == 2'b00);
    c_cal_load: cover property (@(posedge clock) disable iff (!rst_n)
        cal_result.vco_we ##1 req.re && req.addr == scal_pkg::OFF_VCO);
    c_hi_rewrite: cover property (@(posedge clock) disable iff (!rst_n)
        wake ##[1:5] sw_we[scal_pkg::IX_T_HI]);
    c_forced_read: cover property (@(posedge clock) disable iff (!rst_n)
        hi_forced && req.re && req.addr == scal_pkg::OFF_T_HI);

endmodule

// ==== pkg/scal_pkg.sv ====
// package: offsets, reset values, masks and carriers of the synth cal register bank
package scal_pkg;

    localparam int NREG = 10;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [5:0] OFF_CP     = 6'h23;
    localparam logic [5:0] OFF_VCO    = 6'h24;
    localparam logic [5:0] OFF_COARSE = 6'h25;
    localparam logic [5:0] OFF_CTRL   = 6'h26;
    localparam logic [5:0] OFF_RES_A  = 6'h29;
    localparam logic [5:0] OFF_RES_B  = 6'h2a;
    localparam logic [5:0] OFF_RES_C  = 6'h2b;
    localparam logic [5:0] OFF_T_HI   = 6'h2c;
    localparam logic [5:0] OFF_T_MID  = 6'h2d;
    localparam logic [5:0] OFF_T_LO   = 6'h2e;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_CP     = 8'ha9;
    localparam logic [7:0] RST_VCO    = 8'h0a;
    localparam logic [7:0] RST_COARSE = 8'h20;
    localparam logic [7:0] RST_CTRL   = 8'h0d;
    localparam logic [7:0] RST_RES_A  = 8'h59;
    localparam logic [7:0] RST_RES_B  = 8'h7f;
    localparam logic [7:0] RST_RES_C  = 8'h3f;
    localparam logic [7:0] RST_T_HI   = 8'h88;
    localparam logic [7:0] RST_T_MID  = 8'h31;
    localparam logic [7:0] RST_T_LO   = 8'h0b;

    // analog-side values forced on wake when converter retention is set
    localparam logic [7:0] T_HI_RET   = 8'h81;
    localparam logic [7:0] T_MID_RET  = 8'h35;

    // ------------------------------------------------------------------
    // implemented-bit masks
    // ------------------------------------------------------------------
    localparam logic [7:0] MASK_ALL    = 8'hff;
    localparam logic [7:0] MASK_VCO    = 8'h3f;
    localparam logic [7:0] MASK_COARSE = 8'h3f;
    localparam logic [7:0] MASK_CTRL   = 8'h7f;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CP_CFG_LSB   = 6;
    localparam int CP_EN_LSB    = 4;
    localparam int CP_RES_LSB   = 0;
    localparam int VCO_CORE_BIT = 5;
    localparam int VCO_CUR_LSB  = 0;
    localparam int VCO_SEL_BIT  = 1;

    // ------------------------------------------------------------------
    // tables indexed by register slot
    // ------------------------------------------------------------------
    localparam logic [NREG-1:0][5:0] REG_OFF = {OFF_T_LO, OFF_T_MID, OFF_T_HI, OFF_RES_C,
        OFF_RES_B, OFF_RES_A, OFF_CTRL, OFF_COARSE, OFF_VCO, OFF_CP};
    localparam logic [NREG-1:0][7:0] REG_RST = {RST_T_LO, RST_T_MID, RST_T_HI, RST_RES_C,
        RST_RES_B, RST_RES_A, RST_CTRL, RST_COARSE, RST_VCO, RST_CP};
    localparam logic [NREG-1:0][7:0] REG_MASK = {MASK_ALL, MASK_ALL, MASK_ALL, MASK_ALL,
        MASK_ALL, MASK_ALL, MASK_CTRL, MASK_COARSE, MASK_VCO, MASK_ALL};
    localparam logic [NREG-1:0] REG_VOLATILE = 10'h3f0;

    localparam int IX_CP     = 0;
    localparam int IX_VCO    = 1;
    localparam int IX_COARSE = 2;
    localparam int IX_CTRL   = 3;
    localparam int IX_RES_A  = 4;
    localparam int IX_RES_B  = 5;
    localparam int IX_RES_C  = 6;
    localparam int IX_T_HI   = 7;
    localparam int IX_T_MID  = 8;
    localparam int IX_T_LO   = 9;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       we;
        logic       re;
        logic [5:0] addr;
        logic [7:0] wdata;
    } scal_req_t;

    typedef struct packed {
        logic       cp_we;
        logic [3:0] cp_res;
        logic       vco_we;
        logic [4:0] vco_cur;
        logic       coarse_we;
        logic [5:0] coarse;
    } scal_result_t;

    typedef struct packed {
        logic [1:0] cal_cfg;
        logic       cp_stage_en;
        logic [3:0] cp_code;
        logic       vco_core_high_select;
        logic [4:0] vco_cur;
        logic [5:0] coarse;
        logic [6:0] cal_ctrl;
        logic       vco_choice_cal_enable;
        logic [7:0] res_a;
        logic [7:0] res_b;
        logic [7:0] res_c;
        logic [7:0] test_high;
        logic [7:0] test_mid;
        logic [7:0] test_low;
    } scal_cfg_t;

endpackage

// ==== testbench/scal_host.sv ====
// host model: drives the parallel strobe port of the synth cal register bank
module scal_host (
    input  wire logic                clock,
    input  wire logic [7:0]          rdata,
    input  wire logic                rvalid,
    output scal_pkg::scal_req_t      req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    // ------------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------------
    // one-cycle write strobe; released lines show inverted data, never the last value
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        req <= '{we: 1'b0, re: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // one-cycle read strobe; data taken at the edge where rvalid is high
    task automatic rd(input logic [5:0] a, output logic [7:0] d, output bit ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge clock);
        req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        req <= '{we: 1'b0, re: 1'b0, addr: ~a, wdata: 8'hff};
        // rvalid rose at the strobe's edge; it is taken at the next edge while it stands
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clock);
            if (rvalid === 1'b1) begin
                d = rdata;
                ok = 1'b1;
            end
        end
    endtask
endmodule

// ==== testbench/synth_cal_and_test_regs_tb.sv ====
// testbench: register access, calibration loads and wake restore of the synth cal bank
module synth_cal_and_test_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clock;
    logic                   rst_n;
    logic                   sleep;
    logic                   converter_retention;
    scal_pkg::scal_req_t    req;
    scal_pkg::scal_result_t cal_result;
    logic [7:0]             rdata;
    logic                   rvalid;
    scal_pkg::scal_cfg_t    cfg;
    int                     error_cnt;
    int                     n_compared;
    logic [7:0]             d;
    bit                     ok;

    scal_regbank uut (.clock(clock), .rst_n(rst_n), .req(req), .cal_result(cal_result),
        .sleep(sleep), .converter_retention(converter_retention), .rdata(rdata),
        .rvalid(rvalid), .cfg(cfg));

    scal_host host (.clock(clock), .rdata(rdata), .rvalid(rvalid), .req(req));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic rchk(input logic [5:0] a, input logic [7:0] e, input string m);
        host.rd(a, d, ok);
        if (!ok) begin
            error_cnt++;
            $display("BAD %0t: no read answer at %h", $time, a);
            summarize();
        end else begin
            chk(d, e, m);
        end
    endtask

    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        $display("BAD %0t: run did not finish", $time);
        summarize();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        sleep = 1'b0;
        converter_retention = 1'b0;
        cal_result = '0;
        error_cnt = 0;
        n_compared = 0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < scal_pkg::NREG; i++) begin
            rchk(scal_pkg::REG_OFF[i], scal_pkg::REG_RST[i], "reset value");
        end
        chk({6'h00, cfg.cal_cfg}, 8'h02, "cal cfg reset");
        chk({7'h00, cfg.cp_stage_en}, 8'h01, "cp stage reset");
        chk({7'h00, cfg.vco_choice_cal_enable}, 8'h01, "vco choice reset");
        // unused bits store zero
        host.wr(scal_pkg::OFF_VCO, 8'hff);
        host.wr(scal_pkg::OFF_COARSE, 8'hff);
        host.wr(scal_pkg::OFF_CTRL, 8'hff);
        rchk(scal_pkg::OFF_VCO, 8'h3f, "vco all ones");
        rchk(scal_pkg::OFF_COARSE, 8'h3f, "coarse all ones");
        rchk(scal_pkg::OFF_CTRL, 8'h7f, "ctrl all ones");
        chk({7'h00, cfg.vco_core_high_select}, 8'h01, "high core");
        chk({3'h0, cfg.vco_cur}, 8'h1f, "vco current cfg");
        chk({1'b0, cfg.cal_ctrl}, 8'h7f, "ctrl cfg");
        host.wr(scal_pkg::OFF_VCO, 8'hc0);
        rchk(scal_pkg::OFF_VCO, 8'h00, "vco unused only");
        chk({7'h00, cfg.vco_core_high_select}, 8'h00, "low core");
        // charge pump stage enable at zero and non-zero
        host.wr(scal_pkg::OFF_CP, 8'h4f);
        repeat (3) @(posedge clock);
        chk({7'h00, cfg.cp_stage_en}, 8'h00, "cp stage off");
        chk({6'h00, cfg.cal_cfg}, 8'h01, "cal cfg write");
        host.wr(scal_pkg::OFF_CP, 8'h1f);
        repeat (3) @(posedge clock);
        chk({7'h00, cfg.cp_stage_en}, 8'h01, "cp stage on");
        // calibration loads keep the other bits
        @(posedge clock);
        cal_result <= '{1'b1, 4'h5, 1'b1, 5'h13, 1'b1, 6'h2a};
        @(posedge clock);
        cal_result <= '{1'b0, 4'ha, 1'b0, 5'h0c, 1'b0, 6'h15};
        repeat (2) @(posedge clock);
        chk({4'h0, cfg.cp_code}, 8'h05, "cp code cfg");
        chk({3'h0, cfg.vco_cur}, 8'h13, "vco cur cfg load");
        chk({2'h0, cfg.coarse}, 8'h2a, "coarse cfg load");
        rchk(scal_pkg::OFF_CP, 8'h15, "cp load");
        rchk(scal_pkg::OFF_VCO, 8'h13, "vco load");
        rchk(scal_pkg::OFF_COARSE, 8'h2a, "coarse load");
        // volatile registers lose contents over sleep
        for (int i = scal_pkg::IX_RES_A; i <= scal_pkg::IX_T_LO; i++) begin
            host.wr(scal_pkg::REG_OFF[i], 8'h00);
        end
        repeat (3) @(posedge clock);
        chk({7'h00, cfg.vco_choice_cal_enable}, 8'h00, "vco choice off");
        @(posedge clock);
        converter_retention <= 1'b1;
        sleep <= 1'b1;
        host.wr(scal_pkg::OFF_CP, 8'h00);
        @(posedge clock);
        sleep <= 1'b0;
        // read strobe lands one cycle after the wake cycle
        rchk(scal_pkg::OFF_T_HI, 8'h88, "high read on wake");
        chk(cfg.test_high, scal_pkg::T_HI_RET, "forced high");
        chk(cfg.test_mid, scal_pkg::T_MID_RET, "forced mid");
        chk(cfg.test_low, scal_pkg::RST_T_LO, "low restored");
        chk(cfg.res_a, scal_pkg::RST_RES_A, "res a restored");
        chk(cfg.res_b, scal_pkg::RST_RES_B, "res b restored");
        chk(cfg.res_c, scal_pkg::RST_RES_C, "res c restored");
        for (int i = scal_pkg::IX_RES_A; i <= scal_pkg::IX_T_LO; i++) begin
            rchk(scal_pkg::REG_OFF[i], scal_pkg::REG_RST[i], "wake value");
        end
        rchk(scal_pkg::OFF_CP, 8'h15, "cal reg kept");
        @(posedge clock);
        converter_retention <= 1'b0;
        repeat (3) @(posedge clock);
        chk(cfg.test_high, 8'h88, "forced high plain");
        chk(cfg.test_mid, 8'h31, "forced mid plain");
        @(posedge clock);
        converter_retention <= 1'b1;
        host.wr(scal_pkg::OFF_T_HI, 8'h5a);
        repeat (3) @(posedge clock);
        chk(cfg.test_high, 8'h5a, "rewrite ends force");
        chk(cfg.test_mid, scal_pkg::T_MID_RET, "mid still forced");
        rchk(scal_pkg::OFF_T_MID, 8'h31, "mid read");
        // second sleep, middle test register read right after wake
        @(posedge clock);
        sleep <= 1'b1;
        @(posedge clock);
        sleep <= 1'b0;
        rchk(scal_pkg::OFF_T_MID, 8'h31, "mid read on wake");
        chk(cfg.test_high, scal_pkg::T_HI_RET, "high forced again");
        rchk(scal_pkg::OFF_T_HI, 8'h88, "high read after wake");
        rchk(6'h27, 8'h00, "unmapped read");
        summarize();
    end
endmodule
